// ---- verilog/quadrature_position_decoder.sv ----
module quadrature_position_decoder
  import qdec_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Encoder pins
  input wire logic phase_a_input_i,
  input wire logic phase_b_input_i,
  input wire logic index_input_i,
  // Processor power state
  input wire logic sleep_i,
  input wire logic idle_i,
  // Direction pin and flag
  output logic count_direction_o,
  output logic count_direction_oe_o,
  output logic block_interrupt_flag_o,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  if (ADDR_W < 14) begin : g_bad
    $error("address too narrow for the register map");
  end

  function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] a);
    reg_sel_e s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0 && (a >> 14) == '0) begin
      unique case (a[13:2])
        CTRL_IDX: s = SEL_CTRL;
        FCTL_IDX: s = SEL_FCTL;
        POS_IDX: s = SEL_POS;
        MAX_IDX: s = SEL_MAX;
        STAT_IDX: s = SEL_STAT;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [CNT_W-1:0] merge16(
    input logic [CNT_W-1:0] old,
    input logic [DATA_W-1:0] d,
    input logic [3:0] strb
  );
    logic [CNT_W-1:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = d[7:0];
    end
    if (strb[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction

  // Control state
  logic count_error_flag, next_count_error_flag;
  logic sidl, next_sidl;
  logic count_direction, next_count_direction;
  decoder_mode_e mode, next_mode;
  logic direction_output_enable, next_direction_output_enable;
  logic index_reset_enable, next_index_reset_enable;
  logic direction_source_select, next_direction_source_select;
  logic count_error_irq_disable, next_count_error_irq_disable;
  logic filter_output_enable, next_filter_output_enable;
  logic [2:0] qeck, next_qeck;
  logic [CNT_W-1:0] pos, next_pos;
  logic [CNT_W-1:0] maximum_count_register, next_maximum_count_register;
  logic flag, next_flag;
  logic [PRE_W-1:0] pre, next_pre;
  logic a_q, b_q, x_q;

  // Bus state
  logic aw_hold, next_aw_hold;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic w_hold, next_w_hold;
  logic [DATA_W-1:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready, next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;

  // Filtered and selected pins
  logic a_f, b_f, x_f;
  logic a_s, b_s, x_s;
  logic run, tick;
  logic [PRE_W-1:0] pre_limit;

  assign run = !sleep_i && !(idle_i && sidl);
  assign pre_limit = PRE_W'((8'h01 << qeck) - 8'h01);
  assign tick = run && (pre >= pre_limit);
  assign a_s = filter_output_enable ? a_f : phase_a_input_i;
  assign b_s = filter_output_enable ? b_f : phase_b_input_i;
  assign x_s = filter_output_enable ? x_f : index_input_i;

  noise_filter #(.SAMPLES(FILTER_SAMPLES)) u_filt_a (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .sample_i(tick),
    .raw_i(phase_a_input_i),
    .filtered_o(a_f)
  );

  noise_filter #(.SAMPLES(FILTER_SAMPLES)) u_filt_b (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .sample_i(tick),
    .raw_i(phase_b_input_i),
    .filtered_o(b_f)
  );

  noise_filter #(.SAMPLES(FILTER_SAMPLES)) u_filt_x (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .sample_i(tick),
    .raw_i(index_input_i),
    .filtered_o(x_f)
  );

  // Registered outputs
  assign count_direction_o = count_direction;
  assign count_direction_oe_o = direction_output_enable;
  assign block_interrupt_flag_o = flag;

  // Counting and registers
  always_comb begin
    logic enc, x4, a_edge, b_edge, pulse, up, idx, tpulse, tup, err;
    logic wr_fire;
    reg_sel_e wsel;
    logic [CNT_W-1:0] nxt;
    logic [CNT_W-1:0] wd;
    enc = mode[2];
    x4 = enc && mode[1];
    a_edge = a_s ^ a_q;
    b_edge = b_s ^ b_q;
    pulse = 1'b0;
    up = 1'b0;
    idx = 1'b0;
    tpulse = 1'b0;
    tup = 1'b0;
    err = 1'b0;
    nxt = pos;
    wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    wsel = reg_decode(aw_addr);
    wd = '0;
    next_count_error_flag = count_error_flag;
    next_sidl = sidl;
    next_count_direction = count_direction;
    next_mode = mode;
    next_direction_output_enable = direction_output_enable;
    next_index_reset_enable = index_reset_enable;
    next_direction_source_select = direction_source_select;
    next_count_error_irq_disable = count_error_irq_disable;
    next_filter_output_enable = filter_output_enable;
    next_qeck = qeck;
    next_pos = pos;
    next_maximum_count_register = maximum_count_register;
    next_flag = flag;
    next_pre = tick ? '0 : (run ? pre + 1'b1 : pre);

    // Software writes; flag clears come first so sets win
    if (wr_fire) begin
      unique case (wsel)
        SEL_CTRL: begin
          wd = merge16('0, w_data, w_strb);
          next_count_error_flag = wd[CTRL_COUNT_ERROR_FLAG_BIT];
          next_sidl = wd[CTRL_SIDL_BIT];
          if (!enc) begin
            next_count_direction = wd[CTRL_COUNT_DIRECTION_BIT];
          end
          next_mode = decoder_mode_e'(wd[CTRL_MODE_LSB+:3]);
          next_direction_output_enable = wd[CTRL_DIRECTION_OUTPUT_ENABLE_BIT];
          next_index_reset_enable = wd[CTRL_INDEX_RESET_ENABLE_BIT];
          next_direction_source_select = wd[CTRL_DIRECTION_SOURCE_SELECT_BIT];
        end
        SEL_FCTL: begin
          wd = merge16('0, w_data, w_strb);
          next_count_error_irq_disable = wd[FCTL_COUNT_ERROR_IRQ_DISABLE_BIT];
          next_filter_output_enable = wd[FCTL_FILTER_OUTPUT_ENABLE_BIT];
          next_qeck = wd[FCTL_QECK_LSB+:3];
        end
        SEL_MAX: next_maximum_count_register = merge16(maximum_count_register, w_data, w_strb);
        SEL_STAT: begin
          if (w_strb[0] && w_data[STAT_FLAG_BIT]) begin
            next_flag = 1'b0;
          end
        end
        SEL_POS, SEL_NONE: ;
      endcase
    end

    // Encoder modes
    if (enc && run) begin
      pulse = x4 ? (a_edge ^ b_edge) : a_edge;
      up = a_edge ? (a_s ^ b_s) : ~(a_s ^ b_s);
      idx = !mode[0] && x_s && !x_q;
    end
    if (pulse) begin
      next_count_direction = up;
      if (!mode[0]) begin
        nxt = up ? pos + 1'b1 : pos - 1'b1;
        err = up ? (nxt == CNT_W'(maximum_count_register + 1'b1))
                 : (nxt == CNT_W'(CNT_ALL_ONES));
        if (err) begin
          next_count_error_flag = 1'b1;
          if (!count_error_irq_disable) begin
            next_flag = 1'b1;
          end
        end
      end else if (up) begin
        nxt = (pos == maximum_count_register) ? '0 : pos + 1'b1;
        if (pos == maximum_count_register) begin
          next_flag = 1'b1;
        end
      end else begin
        nxt = (pos == '0) ? maximum_count_register : pos - 1'b1;
        if (pos == '0) begin
          next_flag = 1'b1;
        end
      end
      next_pos = nxt;
    end
    if (idx) begin
      next_flag = 1'b1;
      if (index_reset_enable) begin
        next_pos = '0;
      end
    end

    // Timer mode on rising phase A
    if (mode == MODE_TIMER && run) begin
      tpulse = a_s && !a_q;
      tup = direction_source_select ? b_s : count_direction;
    end
    if (tpulse) begin
      if (tup) begin
        next_pos = (pos == maximum_count_register) ? '0 : pos + 1'b1;
        if (pos == maximum_count_register) begin
          next_flag = 1'b1;
        end
      end else begin
        next_pos = (pos == '0) ? maximum_count_register : pos - 1'b1;
        if (pos == '0) begin
          next_flag = 1'b1;
        end
      end
    end

    // Direct count write overrides counting
    if (wr_fire && wsel == SEL_POS) begin
      next_pos = merge16(pos, w_data, w_strb);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      count_error_flag <= 1'b0;
      sidl <= 1'b0;
      count_direction <= 1'b0;
      mode <= MODE_OFF;
      direction_output_enable <= 1'b0;
      index_reset_enable <= 1'b0;
      direction_source_select <= 1'b0;
      count_error_irq_disable <= 1'b0;
      filter_output_enable <= 1'b0;
      qeck <= 3'h0;
      pos <= POS_RESET;
      maximum_count_register <= MAX_RESET;
      flag <= 1'b0;
      pre <= '0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      x_q <= 1'b0;
    end else begin
      count_error_flag <= next_count_error_flag;
      sidl <= next_sidl;
      count_direction <= next_count_direction;
      mode <= next_mode;
      direction_output_enable <= next_direction_output_enable;
      index_reset_enable <= next_index_reset_enable;
      direction_source_select <= next_direction_source_select;
      count_error_irq_disable <= next_count_error_irq_disable;
      filter_output_enable <= next_filter_output_enable;
      qeck <= next_qeck;
      pos <= next_pos;
      maximum_count_register <= next_maximum_count_register;
      flag <= next_flag;
      pre <= next_pre;
      a_q <= a_s;
      b_q <= b_s;
      x_q <= x_s;
    end
  end

  // Bus slave
  always_comb begin
    logic wr_fire;
    reg_sel_e rsel;
    logic [CNT_W-1:0] rd;
    wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    rsel = reg_decode(s_axi_araddr);
    rd = '0;
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready || !s_axi_rvalid;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (reg_decode(aw_addr) == SEL_NONE) ? RESP_SLVERR
                                                      : RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;

    unique case (rsel)
      SEL_CTRL: begin
        rd[CTRL_COUNT_ERROR_FLAG_BIT] = count_error_flag;
        rd[CTRL_SIDL_BIT] = sidl;
        rd[CTRL_INDEX_BIT] = x_s;
        rd[CTRL_COUNT_DIRECTION_BIT] = count_direction;
        rd[CTRL_MODE_LSB+:3] = mode;
        rd[CTRL_DIRECTION_OUTPUT_ENABLE_BIT] = direction_output_enable;
        rd[CTRL_INDEX_RESET_ENABLE_BIT] = index_reset_enable;
        rd[CTRL_DIRECTION_SOURCE_SELECT_BIT] = direction_source_select;
      end
      SEL_FCTL: begin
        rd[FCTL_COUNT_ERROR_IRQ_DISABLE_BIT] = count_error_irq_disable;
        rd[FCTL_FILTER_OUTPUT_ENABLE_BIT] = filter_output_enable;
        rd[FCTL_QECK_LSB+:3] = qeck;
      end
      SEL_POS: rd = pos;
      SEL_MAX: rd = maximum_count_register;
      SEL_STAT: rd[STAT_FLAG_BIT] = flag;
      SEL_NONE: rd = '0;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, rd};
      next_rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

// ---- inc/qdec_pkg.sv ----
package qdec_pkg;

  // Bus widths and answers
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [11:0] CTRL_IDX = 12'h122;
  localparam logic [11:0] FCTL_IDX = 12'h124;
  localparam logic [11:0] POS_IDX = 12'h126;
  localparam logic [11:0] MAX_IDX = 12'h128;
  localparam logic [11:0] STAT_IDX = 12'h12a;

  // Decoder control register fields
  localparam int CTRL_COUNT_ERROR_FLAG_BIT = 15;
  localparam int CTRL_SIDL_BIT = 13;
  localparam int CTRL_INDEX_BIT = 12;
  localparam int CTRL_COUNT_DIRECTION_BIT = 11;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_DIRECTION_OUTPUT_ENABLE_BIT = 6;
  localparam int CTRL_INDEX_RESET_ENABLE_BIT = 2;
  localparam int CTRL_DIRECTION_SOURCE_SELECT_BIT = 0;

  // Filter control register fields
  localparam int FCTL_COUNT_ERROR_IRQ_DISABLE_BIT = 8;
  localparam int FCTL_FILTER_OUTPUT_ENABLE_BIT = 7;
  localparam int FCTL_QECK_LSB = 4;

  // Status register fields
  localparam int STAT_FLAG_BIT = 0;

  // Reset values and the all-ones count
  localparam logic [CNT_W-1:0] POS_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] MAX_RESET = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hffff;

  // Filter depth and prescaler width
  localparam int FILTER_SAMPLES = 3;
  localparam int PRE_W = 7;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_TIMER = 3'b001,
    MODE_RSV2 = 3'b010,
    MODE_RSV3 = 3'b011,
    MODE_X2_INDEX = 3'b100,
    MODE_X2_MATCH = 3'b101,
    MODE_X4_INDEX = 3'b110,
    MODE_X4_MATCH = 3'b111
  } decoder_mode_e;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_FCTL = 3'b010,
    SEL_POS = 3'b011,
    SEL_MAX = 3'b100,
    SEL_STAT = 3'b101
  } reg_sel_e;

endpackage

// ---- verilog/noise_filter.sv ----
module noise_filter
  import qdec_pkg::*;
#(
  parameter int SAMPLES = FILTER_SAMPLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Sample strobe and pin
  input wire logic sample_i,
  input wire logic raw_i,
  // Filtered level
  output logic filtered_o
);

  logic [SAMPLES-1:0] hist;
  logic [SAMPLES-1:0] next_hist;
  logic next_filtered;

  if (SAMPLES < 2) begin : g_bad
    $error("noise_filter needs at least two samples");
  end

  // Output moves only after equal samples in a row
  always_comb begin
    next_hist = hist;
    next_filtered = filtered_o;
    if (sample_i) begin
      next_hist = {hist[SAMPLES-2:0], raw_i};
      if (&next_hist) begin
        next_filtered = 1'b1;
      end else if (~|next_hist) begin
        next_filtered = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      hist <= '0;
      filtered_o <= 1'b0;
    end else begin
      hist <= next_hist;
      filtered_o <= next_filtered;
    end
  end

endmodule

// ---- dv/qdec_properties.sv ----
module qdec_properties
  import qdec_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // Pins and power state
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic phase_a_input_i,
  input wire logic phase_b_input_i,
  input wire logic index_input_i,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire logic count_direction_o,
  input wire logic count_direction_oe_o,
  input wire logic block_interrupt_flag_o,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [ADDR_W-1:0] aw_q;
  logic [15:0] w_q;
  logic [2:0] mode_q;
  logic filter_output_enable_q;
  logic enc;
  logic wr_ctrl;
  assign wr_ctrl = aw_q == ADDR_W'({CTRL_IDX, 2'b00});
  assign enc = mode_q[2] && !filter_output_enable_q && !sleep_i && !idle_i;
  // Shadow of the mode and filter enable, taken as each write lands
  always_ff @(posedge ref_clk_i) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[15:0];
    if (!resetn_i) begin
      mode_q <= 3'h0;
      filter_output_enable_q <= 1'b0;
    end else if ($rose(s_axi_bvalid)) begin
      if (wr_ctrl) mode_q <= w_q[10:8];
      if (aw_q == ADDR_W'({FCTL_IDX, 2'b00})) filter_output_enable_q <= w_q[7];
    end
  end
  property p_dir_up;
    $rose(phase_a_input_i) && !phase_b_input_i && enc
      |-> ##[1:3] count_direction_o;
  endproperty
  a_dir_up: assert property (p_dir_up)
    else $error("direction not up");
  property p_dir_down;
    $rose(phase_b_input_i) && !phase_a_input_i && enc && mode_q[1]
      |-> ##[1:3] !count_direction_o;
  endproperty
  a_dir_down: assert property (p_dir_down)
    else $error("direction not down");
  property p_oe_set;
    $rose(s_axi_bvalid) && wr_ctrl |-> count_direction_oe_o == w_q[6];
  endproperty
  a_oe_set: assert property (p_oe_set)
    else $error("direction pin enable wrong");
  property p_oe_hold;
    !$rose(s_axi_bvalid) |-> $stable(count_direction_oe_o);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("direction pin enable moved");
  property p_flag_clear;
    $fell(block_interrupt_flag_o) |-> $rose(s_axi_bvalid);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag cleared without write");
  property p_index_flag;
    $rose(index_input_i) && enc && !mode_q[0]
      |-> ##[1:3] block_interrupt_flag_o;
  endproperty
  a_index_flag: assert property (p_index_flag)
    else $error("index did not set flag");
  property p_sleep;
    sleep_i && $past(sleep_i) && !$rose(s_axi_bvalid)
      |-> $stable(count_direction_o) && $stable(block_interrupt_flag_o);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("activity during sleep");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  property p_rd_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
  endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("read channel not released");
  c_index: cover property ($rose(index_input_i) && enc);
  c_flag: cover property ($rose(block_interrupt_flag_o));
  c_oe: cover property ($rose(count_direction_oe_o));
endmodule

// ---- dv/encoder_model.sv ----
module encoder_model (
  // Clock
  input wire logic ref_clk_i,
  // Encoder outputs
  output logic phase_a_o,
  output logic phase_b_o,
  output logic index_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  logic mark_q = 1'b0;
  // Sequence 00, 10, 11, 01: forward has A leading B
  assign phase_a_o = ph[1] ^ ph[0];
  assign phase_b_o = ph[1];
  assign index_o = mark_q;
  task automatic step(input logic up, input int gap);
    @(posedge ref_clk_i);
    ph <= up ? ph + 2'h1 : ph - 2'h1;
    repeat (gap) @(posedge ref_clk_i);
  endtask
  // Index only while both phases are low
  task automatic mark();
    while (ph != 2'h0) step(1'b1, 3);
    @(posedge ref_clk_i);
    mark_q <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    mark_q <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule

// ---- dv/tb_quadrature_position_decoder.sv ----
module tb_quadrature_position_decoder
  import qdec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(w, e, g) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s expected %h seen %h", w, e, g); end end
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, sleep_i = 1'b0, idle_i = 1'b0;
  logic phase_a_input_i, phase_b_input_i, index_input_i;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, count_direction_o, count_direction_oe_o;
  logic block_interrupt_flag_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] d;
  logic [1:0] r;
  logic [11:0] idx [5] = '{CTRL_IDX, FCTL_IDX, POS_IDX, MAX_IDX, STAT_IDX};
  logic [15:0] rv [5] = '{16'h0, 16'h0, 16'h0, 16'hffff, 16'h0};
  int mismatches = 0, total_checks = 0, cycles = 0;
  encoder_model encoder_model_i (.ref_clk_i, .phase_a_o(phase_a_input_i),
    .phase_b_o(phase_b_input_i), .index_o(index_input_i));
  quadrature_position_decoder #(.ADDR_W(14)) quadrature_position_decoder_i (
    .ref_clk_i, .resetn_i, .phase_a_input_i, .phase_b_input_i, .index_input_i,
    .sleep_i, .idle_i, .count_direction_o, .count_direction_oe_o,
    .block_interrupt_flag_o, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[15:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [11:0] a, input logic [15:0] e);
    rd({a, 2'b00});
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task automatic mv(input logic up, input int n, input int gap = 3);
    repeat (n) encoder_model_i.step(up, gap);
  endtask
  task automatic done(input string n);
    $display("Test %s done", n);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    foreach (idx[i]) chk(idx[i], rv[i]);
    rd(14'h04ac);
    `CHK("unmapped", {RESP_SLVERR, 16'h0}, {r, d})
    wr(12'h12b, 16'h0001);
    `CHK("unmapped write", RESP_SLVERR, r)
    done("reset");
    wr(MAX_IDX, 16'h0005);
    wr(CTRL_IDX, 16'h0740);
    mv(1, 8);
    chk(POS_IDX, 16'h0002);
    `CHK("dir", 1'b1, count_direction_o)
    `CHK("dir enable", 1'b1, count_direction_oe_o)
    `CHK("flag", 1'b1, block_interrupt_flag_o)
    wr(STAT_IDX, 16'h0001);
    `CHK("clear resp", RESP_OKAY, r)
    chk(STAT_IDX, 16'h0000);
    mv(0, 3);
    chk(POS_IDX, 16'h0005);
    `CHK("dir", 1'b0, count_direction_o)
    wr(CTRL_IDX, 16'h0f40);
    chk(CTRL_IDX, 16'h0740);
    done("x4");
    wr(STAT_IDX, 16'h0001);
    wr(CTRL_IDX, 16'h0500);
    mv(1, 4);
    chk(POS_IDX, 16'h0001);
    chk(STAT_IDX, 16'h0001);
    done("x2");
    wr(CTRL_IDX, 16'h0101);
    chk(POS_IDX, 16'h0001);
    mv(1, 4);
    chk(POS_IDX, 16'h0000);
    wr(CTRL_IDX, 16'h0900);
    mv(1, 8);
    chk(POS_IDX, 16'h0002);
    wr(STAT_IDX, 16'h0001);
    wr(POS_IDX, 16'h0005);
    mv(1, 4);
    chk(POS_IDX, 16'h0000);
    chk(STAT_IDX, 16'h0001);
    done("timer");
    mv(0, 1);
    wr(FCTL_IDX, 16'h0090);
    wr(POS_IDX, 16'h0000);
    mv(1, 1, 2);
    mv(0, 1, 12);
    chk(POS_IDX, 16'h0000);
    mv(1, 1, 12);
    mv(0, 1, 12);
    chk(POS_IDX, 16'h0001);
    wr(FCTL_IDX, 16'h0000);
    done("filter");
    wr(CTRL_IDX, 16'h0604);
    wr(STAT_IDX, 16'h0001);
    wr(POS_IDX, 16'h0007);
    encoder_model_i.mark();
    chk(POS_IDX, 16'h0000);
    chk(STAT_IDX, 16'h0001);
    wr(CTRL_IDX, 16'h0600);
    wr(STAT_IDX, 16'h0001);
    mv(1, 4);
    encoder_model_i.mark();
    chk(POS_IDX, 16'h0004);
    chk(STAT_IDX, 16'h0001);
    wr(STAT_IDX, 16'h0001);
    wr(POS_IDX, 16'hfffe);
    mv(1, 2);
    chk(STAT_IDX, 16'h0000);
    wr(POS_IDX, 16'h0005);
    mv(1, 1);
    chk(CTRL_IDX, 16'h8e00);
    chk(STAT_IDX, 16'h0001);
    wr(CTRL_IDX, 16'h0600);
    chk(CTRL_IDX, 16'h0e00);
    wr(STAT_IDX, 16'h0001);
    wr(FCTL_IDX, 16'h0100);
    wr(POS_IDX, 16'h0005);
    mv(1, 1);
    chk(CTRL_IDX, 16'h8e00);
    chk(STAT_IDX, 16'h0000);
    done("index");
    wr(POS_IDX, 16'h0000);
    sleep_i <= 1'b1;
    mv(1, 4);
    sleep_i <= 1'b0;
    chk(POS_IDX, 16'h0000);
    idle_i <= 1'b1;
    mv(1, 4);
    chk(POS_IDX, 16'h0004);
    wr(CTRL_IDX, 16'h2600);
    mv(1, 4);
    chk(POS_IDX, 16'h0004);
    idle_i <= 1'b0;
    done("power");
    wr(CTRL_IDX, 16'h0000);
    mv(1, 4);
    chk(POS_IDX, 16'h0004);
    wr(CTRL_IDX, 16'h0400);
    mv(1, 4);
    chk(POS_IDX, 16'h0006);
    chk(CTRL_IDX, 16'h8c00);
    chk(STAT_IDX, 16'h0000);
    done("x2 index");
    stop_test();
  end
endmodule
bind quadrature_position_decoder qdec_properties #(.ADDR_W(ADDR_W))
  qdec_properties_i (.ref_clk_i, .resetn_i, .phase_a_input_i,
  .phase_b_input_i, .index_input_i, .sleep_i, .idle_i, .count_direction_o,
  .count_direction_oe_o, .block_interrupt_flag_o, .s_axi_awvalid,
  .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready);
